//--- core/tcs_touch_slave.sv
// Touch controller host side: two-wire slave, reset, power-down, data ready.
// Assumes open-drain pads outside, a free-running link_clk well above the
// bus bit rate, and a touch core that pushes report bytes on sys_clk.
// Notes on behaviour
// - Power-down drops the clock-run enable; no report byte leaves the buffer.
// - Only reset or a bus START leaves power-down.
// - Reset pin is active low; any low pulse of 1us fully resets.
// - Device is a bus slave only and works up to 400 kbit/s.
// - Lines are pulled up; parties only pull low or release.
// - Transfers open with START; each START restarts the slave's transfer.
// - A 7-bit address follows START and selects the device on match.
// - Bytes are eight bits, MSB first, each followed by an acknowledge.
// - START is data falling while clock is high.
// - STOP is data rising while clock is high.
// - Data changes only while clock is low.
`timescale 1ns/1ps
`default_nettype none

package tcs_pkg;
    localparam int            BYTE_W      = 8;
    localparam int            FIFO_DEPTH  = 4;
    localparam logic [6:0]    ADDR_BASE   = 7'h40;
    localparam logic [7:0]    FILL_BYTE   = 8'hff;
    localparam logic [2:0]    BIT_LAST    = 3'h7;
    localparam logic [2:0]    BIT_ONE     = 3'h1;
    localparam logic [1:0]    STRAP_WAIT  = 2'h3;
    localparam logic [1:0]    STRAP_ONE   = 2'h1;
    typedef enum logic [0:0] {TCS_RUN, TCS_DOWN} tcs_pwr_t;
    typedef enum logic [3:0] {
        TCS_IDLE, TCS_ADDR, TCS_ADDR_CHK, TCS_ACK_A, TCS_WRITE,
        TCS_WR_CHK, TCS_ACK_W, TCS_READ, TCS_RD_LAST, TCS_RD_ACK,
        TCS_IGNORE
    } tcs_link_t;
endpackage

module tcs_touch_slave
    import tcs_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR_BASE = ADDR_BASE
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              link_clk,
    input  wire logic              scl_i,
    output var  logic              scl_o,
    output var  logic              scl_oe,
    input  wire logic              sda_i,
    output var  logic              sda_o,
    output var  logic              sda_oe,
    input  wire logic              slave_addr_pick_0,
    input  wire logic              slave_addr_pick_1,
    input  wire logic              panel_sensor_choice,
    output var  logic              panel_sensor_sel,
    input  wire logic              report_valid,
    input  wire logic [BYTE_W-1:0] report_data,
    output var  logic              report_ready,
    input  wire logic              power_down_req,
    output var  logic              clocks_run,
    output var  logic              data_ready
);
    typedef struct packed {
        tcs_pwr_t          st;
        logic [2:0]        strap_m;
        logic [2:0]        strap_s;
        logic [1:0]        strap_cnt;
        logic              strap_done;
        logic [1:0]        addr_pick;
        logic              panel_sel;
        logic [1:0]        ack_sync;
        logic [1:0]        wake_sync;
        logic              wake_prev;
        logic              pd_prev;
        logic              req_tog;
        logic [BYTE_W-1:0] hold;
        logic              clk_run;
        logic              rdy_flag;
    } tcs_sys_t;

    typedef struct packed {
        tcs_link_t         st;
        logic [1:0]        scl_sync;
        logic [1:0]        sda_sync;
        logic              scl_prev;
        logic              sda_prev;
        logic [1:0]        req_sync;
        logic [1:0]        pick_m;
        logic [1:0]        pick_s;
        logic [2:0]        cnt;
        logic [BYTE_W-1:0] sh;
        logic              rw;
        logic              ack_tog;
        logic              wake_tog;
        logic              sda_oe;
        logic              sda_o;
        logic              scl_oe;
        logic              scl_o;
    } tcs_lnk_t;

    tcs_sys_t          sys_reg;
    tcs_sys_t          sys_next;
    tcs_lnk_t          lnk_reg;
    tcs_lnk_t          lnk_next;
    logic              fifo_valid;
    logic [BYTE_W-1:0] fifo_data;
    logic              fifo_pop;
    logic              busy;
    logic              wake_edge;
    logic              scl_s;
    logic              sda_s;
    logic              scl_rise;
    logic              scl_fall;
    logic              bus_start;
    logic              bus_stop;
    logic              hold_full;
    logic [6:0]        my_addr;
    logic [BYTE_W-1:0] rx_byte;

    tcs_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (report_valid),
        .in_data   (report_data),
        .in_ready  (report_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_data),
        .out_ready (fifo_pop)
    );

    // System side
    assign busy      = sys_reg.req_tog ^ sys_reg.ack_sync[1];
    assign wake_edge = sys_reg.wake_sync[1] ^ sys_reg.wake_prev;
    assign fifo_pop  = (sys_reg.st == TCS_RUN) && !busy && fifo_valid;

    always_comb begin
        sys_next = sys_reg;
        sys_next.strap_m   = {slave_addr_pick_1, slave_addr_pick_0,
                              panel_sensor_choice};
        sys_next.strap_s   = sys_reg.strap_m;
        sys_next.ack_sync  = {sys_reg.ack_sync[0], lnk_reg.ack_tog};
        sys_next.wake_sync = {sys_reg.wake_sync[0], lnk_reg.wake_tog};
        sys_next.wake_prev = sys_reg.wake_sync[1];
        sys_next.pd_prev   = power_down_req;
        if (!sys_reg.strap_done) begin
            sys_next.strap_cnt = sys_reg.strap_cnt + STRAP_ONE;
            if (sys_reg.strap_cnt == STRAP_WAIT) begin
                sys_next.strap_done = 1'b1;
                sys_next.addr_pick  = sys_reg.strap_s[2:1];
                sys_next.panel_sel  = sys_reg.strap_s[0];
            end
        end
        case (sys_reg.st)
            TCS_RUN: begin
                if (power_down_req && !sys_reg.pd_prev) begin
                    sys_next.st = TCS_DOWN;
                end
            end
            TCS_DOWN: begin
                if (wake_edge) begin
                    sys_next.st = TCS_RUN;
                end
            end
            default: begin
                sys_next.st = TCS_RUN;
            end
        endcase
        sys_next.clk_run = (sys_next.st == TCS_RUN);
        if (fifo_pop) begin
            sys_next.hold    = fifo_data;
            sys_next.req_tog = ~sys_reg.req_tog;
        end
        sys_next.rdy_flag = fifo_valid || busy;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_reg         <= '0;
            sys_reg.st      <= TCS_RUN;
            sys_reg.clk_run <= 1'b1;
        end else begin
            sys_reg <= sys_next;
        end
    end

    assign clocks_run       = sys_reg.clk_run;
    assign data_ready       = sys_reg.rdy_flag;
    assign panel_sensor_sel = sys_reg.panel_sel;

    // Link side
    assign scl_s     = lnk_reg.scl_sync[1];
    assign sda_s     = lnk_reg.sda_sync[1];
    assign scl_rise  = scl_s && !lnk_reg.scl_prev;
    assign scl_fall  = !scl_s && lnk_reg.scl_prev;
    assign bus_start = scl_s && lnk_reg.scl_prev && lnk_reg.sda_prev && !sda_s;
    assign bus_stop  = scl_s && lnk_reg.scl_prev && !lnk_reg.sda_prev && sda_s;
    assign hold_full = lnk_reg.req_sync[1] ^ lnk_reg.ack_tog;
    assign my_addr   = {SLAVE_ADDR_BASE[6:2], lnk_reg.pick_s};
    assign rx_byte   = {lnk_reg.sh[BYTE_W-2:0], sda_s};

    always_comb begin
        logic load;
        load = 1'b0;
        lnk_next = lnk_reg;
        // Oversampled pins; link_clk must outpace the bit rate
        lnk_next.scl_sync = {lnk_reg.scl_sync[0], scl_i};
        lnk_next.sda_sync = {lnk_reg.sda_sync[0], sda_i};
        lnk_next.req_sync = {lnk_reg.req_sync[0], sys_reg.req_tog};
        lnk_next.pick_m   = sys_reg.addr_pick;
        lnk_next.pick_s   = lnk_reg.pick_m;
        lnk_next.scl_prev = scl_s;
        lnk_next.sda_prev = sda_s;
        case (lnk_reg.st)
            TCS_ADDR, TCS_WRITE: begin
                if (scl_rise) begin
                    lnk_next.sh  = rx_byte;
                    lnk_next.cnt = lnk_reg.cnt + BIT_ONE;
                    if (lnk_reg.cnt == BIT_LAST) begin
                        lnk_next.st = (lnk_reg.st == TCS_ADDR) ? TCS_ADDR_CHK
                                                               : TCS_WR_CHK;
                    end
                end
            end
            TCS_ADDR_CHK: begin
                if (scl_fall) begin
                    if (lnk_reg.sh[BYTE_W-1:1] == my_addr) begin
                        lnk_next.sda_oe = 1'b1;
                        lnk_next.rw     = lnk_reg.sh[0];
                        lnk_next.st     = TCS_ACK_A;
                    end else begin
                        lnk_next.st = TCS_IGNORE;
                    end
                end
            end
            TCS_ACK_A: begin
                if (scl_fall) begin
                    lnk_next.sda_oe = 1'b0;
                    lnk_next.cnt    = '0;
                    if (lnk_reg.rw) begin
                        load        = 1'b1;
                        lnk_next.st = TCS_READ;
                    end else begin
                        lnk_next.st = TCS_WRITE;
                    end
                end
            end
            TCS_WR_CHK: begin
                if (scl_fall) begin
                    lnk_next.sda_oe = 1'b1;
                    lnk_next.st     = TCS_ACK_W;
                end
            end
            TCS_ACK_W: begin
                if (scl_fall) begin
                    lnk_next.sda_oe = 1'b0;
                    lnk_next.cnt    = '0;
                    lnk_next.st     = TCS_WRITE;
                end
            end
            TCS_READ: begin
                if (scl_rise) begin
                    lnk_next.cnt = lnk_reg.cnt + BIT_ONE;
                    if (lnk_reg.cnt == BIT_LAST) begin
                        lnk_next.st = TCS_RD_LAST;
                    end
                end
                // Next bit only on low clock
                if (scl_fall) begin
                    lnk_next.sh     = {lnk_reg.sh[BYTE_W-2:0], 1'b0};
                    lnk_next.sda_oe = ~lnk_reg.sh[BYTE_W-2];
                end
            end
            TCS_RD_LAST: begin
                if (scl_fall) begin
                    lnk_next.sda_oe = 1'b0;
                    lnk_next.st     = TCS_RD_ACK;
                end
            end
            TCS_RD_ACK: begin
                // Host acknowledge low asks for one more byte
                if (scl_rise && sda_s) begin
                    lnk_next.st = TCS_IGNORE;
                end else if (scl_fall) begin
                    load         = 1'b1;
                    lnk_next.cnt = '0;
                    lnk_next.st  = TCS_READ;
                end
            end
            default: begin
                lnk_next.sda_oe = 1'b0;
            end
        endcase
        if (load) begin
            // Empty hold sends filler rather than stretching the clock
            lnk_next.sh     = hold_full ? sys_reg.hold : FILL_BYTE;
            lnk_next.sda_oe = hold_full ? ~sys_reg.hold[BYTE_W-1]
                                        : ~FILL_BYTE[BYTE_W-1];
            if (hold_full) begin
                lnk_next.ack_tog = ~lnk_reg.ack_tog;
            end
        end
        if (bus_start) begin
            lnk_next.st       = TCS_ADDR;
            lnk_next.cnt      = '0;
            lnk_next.sda_oe   = 1'b0;
            lnk_next.wake_tog = ~lnk_reg.wake_tog;
        end else if (bus_stop) begin
            lnk_next.st     = TCS_IDLE;
            lnk_next.sda_oe = 1'b0;
        end
        lnk_next.sda_o  = 1'b0;
        lnk_next.scl_o  = 1'b0;
        lnk_next.scl_oe = 1'b0;
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lnk_reg          <= '0;
            lnk_reg.st       <= TCS_IDLE;
            lnk_reg.scl_sync <= 2'h3;
            lnk_reg.sda_sync <= 2'h3;
            lnk_reg.scl_prev <= 1'b1;
            lnk_reg.sda_prev <= 1'b1;
        end else begin
            lnk_reg <= lnk_next;
        end
    end

    assign sda_o  = lnk_reg.sda_o;
    assign sda_oe = lnk_reg.sda_oe;
    assign scl_o  = lnk_reg.scl_o;
    assign scl_oe = lnk_reg.scl_oe;

    chk_pd_stalls_fifo: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        (sys_reg.st == TCS_DOWN) |-> (!fifo_pop && !clocks_run))
        else $error("report path moved in power-down");
    chk_wake_only_start: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        (sys_reg.st == TCS_DOWN) ##1 (sys_reg.st == TCS_RUN)
        |-> $past(wake_edge))
        else $error("power-down left without bus wake");
    chk_wake_exit_now: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        (sys_reg.st == TCS_DOWN && wake_edge) |=> clocks_run)
        else $error("bus wake did not restart clocks");
    // Push to flag crosses the buffer and its head register
    chk_ready_on_report: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        (report_valid && report_ready) |-> ##[1:4] data_ready)
        else $error("data ready missing after report push");
    chk_ready_drop_read: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        (!fifo_valid && !busy) |=> !data_ready)
        else $error("data ready held after report read");
    chk_start_restart: assert property (@(posedge link_clk)
        disable iff (!rst_n)
        bus_start |=> (lnk_reg.st == TCS_ADDR && lnk_reg.cnt == '0
                       && !sda_oe))
        else $error("start did not restart transfer");
    chk_stop_idle: assert property (@(posedge link_clk)
        disable iff (!rst_n)
        bus_stop |=> (lnk_reg.st == TCS_IDLE && !sda_oe))
        else $error("stop did not return to idle");
    chk_oe_low_clock: assert property (@(posedge link_clk)
        disable iff (!rst_n)
        $changed(sda_oe) |-> !lnk_reg.scl_prev || $past(bus_stop)
                             || $past(bus_start))
        else $error("data moved while clock high");
    chk_nomatch_quiet: assert property (@(posedge link_clk)
        disable iff (!rst_n)
        (lnk_reg.st == TCS_IGNORE) |-> !sda_oe)
        else $error("pulled data line while unselected");
    chk_match_acks: assert property (@(posedge link_clk)
        disable iff (!rst_n)
        (lnk_reg.st == TCS_ADDR_CHK && scl_fall && !bus_start && !bus_stop
         && lnk_reg.sh[BYTE_W-1:1] == my_addr) |=> sda_oe)
        else $error("matching address not acknowledged");
    chk_byte_eight: assert property (@(posedge link_clk)
        disable iff (!rst_n)
        (lnk_reg.st == TCS_READ) ##1 (lnk_reg.st == TCS_RD_LAST)
        |-> ($past(lnk_reg.cnt) == BIT_LAST))
        else $error("read byte not eight bits");
    chk_drive_low: assert property (@(posedge link_clk)
        disable iff (!rst_n) !sda_o && !scl_o && !scl_oe)
        else $error("line driven high");

    cov_read_byte: cover property (@(posedge link_clk) disable iff (!rst_n)
        lnk_reg.st == TCS_RD_ACK ##1 lnk_reg.st == TCS_READ);
    cov_write_ack: cover property (@(posedge link_clk) disable iff (!rst_n)
        lnk_reg.st == TCS_ACK_W);
    cov_no_match: cover property (@(posedge link_clk) disable iff (!rst_n)
        lnk_reg.st == TCS_ADDR_CHK ##1 lnk_reg.st == TCS_IGNORE);
    cov_pd_wake: cover property (@(posedge sys_clk) disable iff (!rst_n)
        sys_reg.st == TCS_DOWN ##1 sys_reg.st == TCS_RUN);
endmodule

`default_nettype wire

//--- core/tcs_fifo.sv
// Small first-in first-out buffer for report bytes, one clock domain.
// Assumes writer and reader both sit on clk; head word comes from a register.
`timescale 1ns/1ps
`default_nettype none

module tcs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output var  logic             in_ready,
    output var  logic             out_valid,
    output var  logic [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [CW-1:0] ONE_CNT  = CW'(1);
    localparam logic [PW-1:0] ONE_PTR  = PW'(1);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [CW-1:0]               cnt;
        logic                        head_vld;
        logic [WIDTH-1:0]            head;
        logic                        rdy;
    } tcs_fifo_st_t;

    tcs_fifo_st_t fifo_reg;
    tcs_fifo_st_t fifo_next;
    logic         push;
    logic         pop;

    assign push      = in_valid && fifo_reg.rdy;
    assign pop       = fifo_reg.head_vld && out_ready;
    assign in_ready  = fifo_reg.rdy;
    assign out_valid = fifo_reg.head_vld;
    assign out_data  = fifo_reg.head;

    always_comb begin
        fifo_next = fifo_reg;
        if (push) begin
            fifo_next.mem[fifo_reg.wp] = in_data;
            fifo_next.wp = (fifo_reg.wp == LAST_PTR) ? '0
                                                      : fifo_reg.wp + ONE_PTR;
        end
        // Head refill reads only old entries, so a push never bypasses
        if ((!fifo_reg.head_vld || pop) && fifo_reg.cnt != '0) begin
            fifo_next.head     = fifo_reg.mem[fifo_reg.rp];
            fifo_next.head_vld = 1'b1;
            fifo_next.rp = (fifo_reg.rp == LAST_PTR) ? '0
                                                      : fifo_reg.rp + ONE_PTR;
            fifo_next.cnt = push ? fifo_reg.cnt : fifo_reg.cnt - ONE_CNT;
        end else begin
            if (pop) begin
                fifo_next.head_vld = 1'b0;
            end
            if (push) begin
                fifo_next.cnt = fifo_reg.cnt + ONE_CNT;
            end
        end
        fifo_next.rdy = (fifo_next.cnt != FULL_CNT);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fifo_reg     <= '0;
            fifo_reg.rdy <= 1'b1;
        end else begin
            fifo_reg <= fifo_next;
        end
    end

    chk_fifo_no_overrun: assert property (@(posedge clk) disable iff (!rst_n)
        (fifo_reg.cnt == FULL_CNT) |-> !in_ready)
        else $error("fifo reports ready while full");
endmodule

`default_nettype wire

//--- tb/tcs_host_model.sv
// Bus master model for the touch slave: open-drain pulls on SCL and SDA.
// Assumes the bench resolves wire levels from all pulls, pulled up.
`timescale 1ns/1ps
`default_nettype none
module tcs_host_model (
    input  wire logic clk,
    input  wire logic sda_w,
    output var  logic scl_pull,
    output var  logic sda_pull
);
    // lines start released, never driven high
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    // quarter bit of 800 ns keeps SCL near 312 kHz
    task automatic q();
        repeat (40) @(negedge clk);
    endtask
    // data falls while clock high, also as repeated start
    task automatic start();
        sda_pull = 1'b0;
        q();
        scl_pull = 1'b0;
        q();
        sda_pull = 1'b1;
        q();
        scl_pull = 1'b1;
        q();
    endtask
    task automatic stop();
        sda_pull = 1'b1;
        q();
        scl_pull = 1'b0;
        q();
        sda_pull = 1'b0;
        q();
    endtask
    // data moves only while clock is low
    task automatic bitx(input logic b, output logic r);
        sda_pull = ~b;
        q();
        scl_pull = 1'b0;
        q();
        r = sda_w;
        q();
        scl_pull = 1'b1;
        q();
    endtask
    // eight bits MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic ack_in,
                        output logic [7:0] r, output logic ack_out);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], b);
            r[i] = b;
        end
        bitx(ack_in, ack_out);
    endtask
endmodule
`default_nettype wire

//--- tb/tcs_touch_slave_tb.sv
// Bench for the touch slave: bus traffic, report path, power-down, reset.
// Assumes the host model in tcs_host_model.sv and pull-ups on both lines.
`timescale 1ns/1ps
`default_nettype none
module tcs_touch_slave_tb
    import tcs_pkg::*;
;
    localparam logic [6:0] MY_ADDR  = {ADDR_BASE[6:2], 2'b01};
    localparam logic [6:0] BAD_ADDR = {ADDR_BASE[6:2], 2'b10};
    logic       sys_clk        = 1'b0;
    logic       link_clk       = 1'b0;
    logic       rst_n          = 1'b0;
    logic       report_valid   = 1'b0;
    logic [7:0] report_data    = 8'h00;
    logic       power_down_req = 1'b0;
    logic       scl_oe, sda_oe, scl_pull, sda_pull;
    logic       panel_sensor_sel, report_ready, clocks_run, data_ready;
    logic       scl_o, sda_o;
    wire        scl_w = ~(scl_pull | scl_oe);
    wire        sda_w = ~(sda_pull | sda_oe);
    int         err_count = 0;
    int         checked   = 0;
    logic [7:0] r;
    logic       a;
    always #10 sys_clk = ~sys_clk;
    initial #7 forever #80 link_clk = ~link_clk;
    tcs_touch_slave dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .link_clk(link_clk), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
        .slave_addr_pick_0(1'b1), .slave_addr_pick_1(1'b0),
        .panel_sensor_choice(1'b1), .panel_sensor_sel(panel_sensor_sel),
        .report_valid(report_valid), .report_data(report_data),
        .report_ready(report_ready), .power_down_req(power_down_req),
        .clocks_run(clocks_run), .data_ready(data_ready));
    tcs_host_model host (.clk(sys_clk), .sda_w(sda_w),
        .scl_pull(scl_pull), .sda_pull(sda_pull));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("Counts: %0d checks, %0d mismatches", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic push(input logic [7:0] d, output logic ok);
        @(negedge sys_clk);
        ok = (report_ready === 1'b1);
        report_valid = ok;
        report_data = d;
        @(negedge sys_clk);
        report_valid = 1'b0;
    endtask
    task automatic t_reset_vals();
        chk({sda_oe, scl_oe, clocks_run, data_ready}, 8'h02);
        chk({7'h0, report_ready}, 8'h01);
        chk({7'h0, panel_sensor_sel}, 8'h01);
        $display("test reset_vals done");
    endtask
    task automatic t_mismatch();
        host.start();
        host.xfer({BAD_ADDR, 1'b0}, 1'b1, r, a);
        chk({7'h0, a}, 8'h01);
        host.xfer(8'h33, 1'b1, r, a);
        chk({7'h0, a}, 8'h01);
        host.stop();
        $display("test mismatch done");
    endtask
    task automatic t_write();
        host.start();
        host.xfer({MY_ADDR, 1'b0}, 1'b1, r, a);
        chk({7'h0, a}, 8'h00);
        chk({5'h0, sda_o, scl_o, scl_oe}, 8'h00);
        host.xfer(8'h5a, 1'b1, r, a);
        chk({7'h0, a}, 8'h00);
        host.start();
        host.xfer({MY_ADDR, 1'b1}, 1'b1, r, a);
        chk({7'h0, a}, 8'h00);
        host.xfer(8'hff, 1'b1, r, a);
        chk(r, FILL_BYTE);
        host.stop();
        $display("test write_restart done");
    endtask
    task automatic t_fill();
        int   k;
        logic ok;
        k = 0;
        ok = 1'b1;
        while (ok && k < 8) begin
            push(8'ha0 + k[7:0], ok);
            if (ok)
                k++;
        end
        chk({7'h0, k >= FIFO_DEPTH}, 8'h01);
        chk({7'h0, report_ready}, 8'h00);
        repeat (5) @(negedge sys_clk);
        chk({7'h0, data_ready}, 8'h01);
        host.start();
        host.xfer({MY_ADDR, 1'b1}, 1'b1, r, a);
        chk({7'h0, a}, 8'h00);
        for (int i = 0; i < k; i++) begin
            host.xfer(8'hff, i == k - 1, r, a);
            chk(r, 8'ha0 + i[7:0]);
        end
        host.stop();
        repeat (5) @(negedge sys_clk);
        chk({7'h0, data_ready}, 8'h00);
        $display("test fill_drain done");
    endtask
    task automatic t_power();
        @(negedge sys_clk);
        power_down_req = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk({7'h0, clocks_run}, 8'h00);
        power_down_req = 1'b0;
        repeat (20) @(negedge sys_clk);
        chk({7'h0, clocks_run}, 8'h00);
        host.start();
        chk({7'h0, clocks_run}, 8'h01);
        host.stop();
        power_down_req = 1'b1;
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b0;
        repeat (50) @(negedge sys_clk);
        chk({clocks_run, data_ready, sda_oe}, 8'h04);
        power_down_req = 1'b0;
        rst_n = 1'b1;
        repeat (12) @(negedge sys_clk);
        chk({7'h0, clocks_run}, 8'h01);
        $display("test power_reset done");
    endtask
    // reset held low from time zero before release
    // supplies ideal from time zero; low span stands for settling
    initial begin
        repeat (12) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (12) @(negedge sys_clk);
        t_reset_vals();
        t_mismatch();
        t_write();
        t_fill();
        t_power();
        wrap_up();
    end
    // About 13 bus bytes of 1440 cycles each, so 80000 leaves wide margin
    initial begin
        repeat (80000) @(posedge sys_clk);
        err_count++;
        $display("[FAIL] %0t ns: watchdog expired", $time);
        wrap_up();
    end
endmodule
`default_nettype wire
